// ### bench/otp_chk.sv
// Wire checker for the two serial ports between host and device
`default_nettype none
module otp_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus port
  input wire logic i2c_scl,
  input wire logic i2c_host_oe_n,
  input wire logic i2c_dev_o,
  input wire logic i2c_dev_oe_n,
  // Trim port
  input wire logic trim_serial_clock,
  input wire logic trim_host_oe_n,
  input wire logic trim_dev_o,
  input wire logic trim_dev_oe_n
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // ****************
  // Clock phases
  // ****************
  a_bus_high_half:
    assert property ($rose(i2c_scl) |-> i2c_scl [*5])
    else $error("bus clock high phase too short");
  a_trim_low_half:
    assert property ($fell(trim_serial_clock) |-> !trim_serial_clock [*5])
    else $error("trim clock low phase too short");

  // ****************
  // Frame start and stop
  // ****************
  a_bus_start_form:
    assert property ($fell(i2c_host_oe_n) && i2c_scl
      |-> i2c_scl [*5] ##1 !i2c_scl)
    else $error("bus start not followed by clock fall");
  // Stop only checked from idle resets; a reset inside a frame is not used
  a_trim_stop_form:
    assert property ($rose(trim_host_oe_n) && trim_serial_clock
      |-> $past(trim_serial_clock, 5) && !$past(trim_serial_clock, 6))
    else $error("trim stop not a half period after clock rise");

  // ****************
  // Device answer bits
  // ****************
  a_bus_dev_edge:
    assert property ($changed(i2c_dev_oe_n) |-> !i2c_scl)
    else $error("device changed bus data while clock high");
  a_trim_dev_hold:
    assert property (trim_serial_clock && $past(trim_serial_clock)
      |-> $stable(trim_dev_oe_n))
    else $error("device trim data moved in high phase");
  a_bus_dev_release:
    assert property ($fell(i2c_dev_oe_n) |-> ##[1:90] i2c_dev_oe_n)
    else $error("device held bus data past one byte");
  a_dev_open_drain:
    assert property (i2c_dev_o == 1'b0 && trim_dev_o == 1'b0)
    else $error("device data output not tied low");

  c_bus_read: cover property ($fell(i2c_dev_oe_n));
  c_trim_read: cover property ($fell(trim_dev_oe_n));
  c_trim_start: cover property ($fell(trim_host_oe_n) && trim_serial_clock);
endmodule : otp_chk
`default_nettype wire

// ### bench/otp_shadow_register_access_tb.sv
// Bench joining host and device over both serial ports
`include "otp_cfg.svh"
`default_nettype none
module otp_shadow_register_access_tb
  import otp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, fuse_blank_n, go, rw, port_sel, load_done, busy, done;
  logic [6:0] addr;
  logic [1:0] passes_used;
  otp_byte_t wdata, rdata, got;
  otp_cfg_t cfg_regs;
  otp_byte_t rm [14];
  otp_byte_t fz [14];
  otp_byte_t gain [3];
  int passes = 0;
  int miscompares = 0;
  int samples_checked = 0;

  otp_if link_if ();
  otp_dev otp_dev_i (.clock(clock), .rst_n(rst_n),
    .fuse_blank_n(fuse_blank_n), .link(link_if), .cfg_regs(cfg_regs),
    .load_done(load_done), .passes_used(passes_used));
  otp_host otp_host_i (.clock(clock), .rst_n(rst_n), .link(link_if),
    .go(go), .rw(rw), .port_sel(port_sel), .addr(addr), .wdata(wdata),
    .busy(busy), .done(done), .rdata(rdata));
  otp_chk otp_chk_i (.clock(clock), .rst_n(rst_n),
    .i2c_scl(link_if.i2c_scl), .i2c_host_oe_n(link_if.i2c_host_oe_n),
    .i2c_dev_o(link_if.i2c_dev_o), .i2c_dev_oe_n(link_if.i2c_dev_oe_n),
    .trim_serial_clock(link_if.trim_serial_clock),
    .trim_host_oe_n(link_if.trim_host_oe_n),
    .trim_dev_o(link_if.trim_dev_o), .trim_dev_oe_n(link_if.trim_dev_oe_n));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ****************
  // Expectation models
  // ****************
  function automatic logic [6:0] addr_of(input int i);
    return (i < 8) ? 7'h10 + 7'(i) : 7'h30 + 7'(i - 8);
  endfunction : addr_of

  // Bytes 0x30 and 0x31 keep their fuses inverted in bit 7
  function automatic otp_byte_t mask_of(input int i);
    return (i == 8 || i == 9) ? 8'h80 : 8'h00;
  endfunction : mask_of

  function automatic otp_byte_t loaded(input int i);
    if (i == 8)
      return (passes == 0) ? 8'h80 : gain[passes - 1] ^ 8'h80;
    return fz[i] ^ mask_of(i);
  endfunction : loaded

  task automatic store_model();
    if (passes < 3)
    begin
      for (int i = 0; i < 14; i++)
        fz[i] = fz[i] | (rm[i] ^ mask_of(i));
      gain[passes] = rm[8] ^ 8'h80;
      passes++;
    end
  endtask : store_model

  // ****************
  // Checking and transfers
  // ****************
  task automatic check(input otp_byte_t seen, input otp_byte_t exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cmp_regs();
    for (int i = 0; i < 14; i++)
      check(cfg_regs[i], rm[i]);
  endtask : cmp_regs

  // Port chosen at random so both serial ports carry every kind of frame
  task automatic xfer(input logic r, input logic [6:0] a, input otp_byte_t d);
    int n;
    @(negedge clock);
    rw = r;
    addr = a;
    wdata = d;
    port_sel = 1'($urandom_range(1));
    go = 1'b1;
    @(negedge clock);
    go = 1'b0;
    check({7'h00, busy}, 8'h01);
    n = 0;
    while (done !== 1'b1 && n < 400)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    got = rdata;
    if (n == 400)
    begin
      miscompares++;
      $display("FAIL %0t frame never completed", $time);
    end
  endtask : xfer

  task automatic power_cycle();
    int n;
    @(negedge clock);
    rst_n = 1'b0;
    repeat (16) @(negedge clock);
    check(cfg_regs[8], 8'h00);
    rst_n = 1'b1;
    n = 0;
    while (load_done !== 1'b1 && n < 10)
    begin
      @(negedge clock);
      n++;
    end
    check({7'h00, load_done}, 8'h01);
    for (int i = 0; i < 14; i++)
      rm[i] = loaded(i);
    cmp_regs();
  endtask : power_cycle

  task automatic round();
    otp_byte_t d;
    xfer(1'b0, `OTP_A_UNLOCK, 8'h01);
    xfer(1'b0, `OTP_A_ACCESS, {6'h00, `OTP_SEL_WRITE});
    for (int i = 0; i < 14; i++)
    begin
      d = (i == 0) ? 8'hff : (i == 9) ? 8'h00 : 8'($urandom);
      xfer(1'b0, addr_of(i), d);
      rm[i] = d;
    end
    xfer(1'b0, 7'h18, 8'h5a);
    cmp_regs();
    xfer(1'b0, `OTP_A_ACCESS, {6'h00, `OTP_SEL_READ});
    for (int i = 0; i < 14; i++)
    begin
      xfer(1'b1, addr_of(i), 8'h00);
      check(got, rm[i]);
    end
    xfer(1'b1, 7'h18, 8'h00);
    check(got, 8'h00);
  endtask : round

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  initial
  begin
    repeat (90000) @(posedge clock);
    miscompares++;
    $display("FAIL %0t watchdog expired", $time);
    results();
  end

  // ****************
  // Main sequence
  // ****************
  initial
  begin
    otp_byte_t d;
    rst_n = 1'b0;
    fuse_blank_n = 1'b0;
    go = 1'b0;
    rw = 1'b0;
    port_sel = 1'b0;
    addr = 7'h00;
    wdata = 8'h00;
    void'($urandom(32'hc317));
    for (int i = 0; i < 14; i++)
      fz[i] = 8'h00;
    repeat (2) @(negedge clock);
    fuse_blank_n = 1'b1;
    power_cycle();
    // Locked: select write refused, register reads give zero
    xfer(1'b0, `OTP_A_ACCESS, 8'h02);
    xfer(1'b1, `OTP_A_ACCESS, 8'h00);
    check({6'h00, got[1:0]}, {6'h00, `OTP_SEL_RST});
    xfer(1'b1, `OTP_BLK1_BASE, 8'h00);
    check(got, 8'h00);
    xfer(1'b0, `OTP_A_UNLOCK, 8'h01);
    for (int c = 0; c < 4; c++)
    begin
      xfer(1'b0, `OTP_A_ACCESS, 8'(c));
      d = 8'($urandom);
      xfer(1'b0, `OTP_BLK0_BASE, d);
      if (c == 2)
        rm[0] = d;
      cmp_regs();
      xfer(1'b1, `OTP_BLK1_BASE, 8'h00);
      check(got, (c == 0) ? 8'h80 : 8'h00);
    end
    // Fourth store must be refused
    for (int k = 0; k < 4; k++)
    begin
      round();
      xfer(1'b0, `OTP_A_CMD, `OTP_CMD_STORE);
      store_model();
      check({6'h00, passes_used}, 8'(passes));
      cmp_regs();
      xfer(1'b0, `OTP_A_CMD, `OTP_CMD_LOAD);
      for (int i = 0; i < 14; i++)
        rm[i] = loaded(i);
      cmp_regs();
      power_cycle();
    end
    results();
  end
endmodule : otp_shadow_register_access_tb
`default_nettype wire

// ### design/otp_cfg.svh
// Constants for the fuse-backed configuration store and its serial link
`ifndef OTP_CFG_SVH
`define OTP_CFG_SVH

// ********************************************************************
// Register addresses
// ********************************************************************
`define OTP_A_UNLOCK 7'h01
`define OTP_A_ACCESS 7'h02
`define OTP_A_CMD 7'h03
`define OTP_BLK0_BASE 7'h10
`define OTP_BLK0_LAST 7'h17
`define OTP_BLK1_BASE 7'h30
`define OTP_BLK1_LAST 7'h35
`define OTP_BLK1_IDX 4'h8

// ********************************************************************
// Field values and reset values
// ********************************************************************
`define OTP_SEL_READ 2'b00
`define OTP_SEL_WRITE 2'b10
`define OTP_SEL_RST 2'b11
`define OTP_CMD_LOAD 8'h01
`define OTP_CMD_STORE 8'h02
`define OTP_UNTRIM 8'h80
`define OTP_UNTRIM_IDX0 8
`define OTP_UNTRIM_IDX1 9
`define OTP_GAIN_IDX 8
`define OTP_PASSES 2'h3

// ********************************************************************
// Frame and timing
// ********************************************************************
`define OTP_CMD_BITS 5'h10
`define OTP_FRAME_BITS 5'h18
`define OTP_CLK_NS 8
`define OTP_LINK_NS 80
`define OTP_HALF_CYC ((`OTP_LINK_NS / `OTP_CLK_NS) / 2)

`endif

// ### design/otp_dev.sv
// Device end: serial slaves and fuse-backed configuration registers
//
// Summary of operation
// - Config registers 0x10-0x17, 0x30-0x35, rewritable
// - Reachable via bus port and trim port
// - Fuse array shadows registers, survives power-down
// - At most three permanent store passes
// - Three gain fuse sets for recalibration
// - Fuse bits only go from 0 to 1
// - Load fuses into registers after reset
// - Write changes registers only, not fuses
// - Read returns current register contents
// - Store programs register contents into fuses
// - Registers lost at reset, fuses kept
// - Host writes replace loaded defaults
// - Access select writable only when unlocked
// - Select 00 grants register reads
// - Select 10 grants register writes
// - Host loads before reading fuse contents
// - 0x30 and 0x31 read 0x80 untrimmed
`include "otp_cfg.svh"
`default_nettype none

// ********************************************************************
// Serial frame receiver, one per port
// ********************************************************************
module otp_link_rx
  import otp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Request to core
  output logic req,
  output logic rw,
  output logic [6:0] addr,
  output otp_byte_t wdata,
  input wire otp_byte_t rdata
);
  typedef struct packed {
    logic c1;
    logic c2;
    logic cp;
    logic d1;
    logic d2;
    logic dp;
    logic active;
    logic [4:0] cnt;
    logic [15:0] sh;
    otp_byte_t tx;
    logic oe_n;
    logic req;
  } otp_rx_t;

  otp_rx_t q;
  otp_rx_t d;
  logic rise;
  logic fall;
  otp_byte_t src;

  always_comb
  begin
    d = q;
    d.req = 1'b0;
    d.c1 = scl_i;
    d.c2 = q.c1;
    d.cp = q.c2;
    d.d1 = sda_i;
    d.d2 = q.d1;
    d.dp = q.d2;
    rise = q.c2 & ~q.cp;
    fall = ~q.c2 & q.cp;
    src = (q.cnt == `OTP_CMD_BITS) ? rdata : q.tx;
    if (q.c2 & q.cp & q.dp & ~q.d2)
    begin
      // Start: data falls while clock high
      d.active = 1'b1;
      d.cnt = 5'h00;
      d.oe_n = 1'b1;
    end
    else if (q.c2 & q.cp & ~q.dp & q.d2)
    begin
      d.active = 1'b0;
      d.oe_n = 1'b1;
    end
    else if (q.active & rise & (q.cnt < `OTP_CMD_BITS))
    begin
      d.sh = {q.sh[14:0], q.d2};
      d.cnt = q.cnt + 5'h01;
      d.req = (q.cnt == `OTP_CMD_BITS - 5'h01);
    end
    else if (q.active & fall & q.sh[15] & (q.cnt >= `OTP_CMD_BITS))
    begin
      // Read data changes only while the clock is low
      if (q.cnt < `OTP_FRAME_BITS)
      begin
        d.oe_n = src[7];
        d.tx = {src[6:0], 1'b0};
        d.cnt = q.cnt + 5'h01;
      end
      else
      begin
        d.oe_n = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '{c1: 1'b1, c2: 1'b1, cp: 1'b1, d1: 1'b1, d2: 1'b1, dp: 1'b1,
             oe_n: 1'b1, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_n = q.oe_n;
  assign req = q.req;
  assign rw = q.sh[15];
  assign addr = q.sh[14:8];
  assign wdata = q.sh[7:0];
endmodule : otp_link_rx

// ********************************************************************
// Device top: register file and fuse array
// ********************************************************************
module otp_dev
  import otp_pkg::*;
(
  // Clock and resets
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fuse_blank_n,
  // Serial ports
  otp_if.dev link,
  // User side
  output otp_cfg_t cfg_regs,
  output logic load_done,
  output logic [1:0] passes_used
);
  typedef struct packed {
    otp_dev_st_t st;
    otp_cfg_t cfg;
    logic unlock;
    logic [1:0] sel;
    logic [1:0][7:0] rd;
    logic done;
  } otp_dev_t;

  typedef struct packed {
    otp_cfg_t bits;
    logic [2:0][7:0] gain;
    logic [1:0] passes;
  } otp_fuse_t;

  otp_dev_t q;
  otp_dev_t d;
  otp_fuse_t f;
  otp_fuse_t fd;
  logic [1:0] p_req;
  logic [1:0] p_rw;
  logic [1:0][6:0] p_addr;
  logic [1:0][7:0] p_wdata;
  logic [1:0] p_o;
  logic [1:0] p_oe_n;
  logic [1:0] scl_pin;
  logic [1:0] sda_pin;
  logic req;
  logic rw;
  logic [6:0] addr;
  otp_byte_t wdata;
  logic pidx;
  logic hit;
  logic [3:0] idx;
  logic store_go;

  assign scl_pin = {link.trim_serial_clock, link.i2c_scl};
  assign sda_pin = {link.trim_serial_data, link.i2c_sda};

  // Both ports share one register file
  for (genvar g = 0; g < 2; g++)
  begin : g_port
    otp_link_rx u_rx (
      .clock(clock),
      .rst_n(rst_n),
      .scl_i(scl_pin[g]),
      .sda_i(sda_pin[g]),
      .sda_o(p_o[g]),
      .sda_oe_n(p_oe_n[g]),
      .req(p_req[g]),
      .rw(p_rw[g]),
      .addr(p_addr[g]),
      .wdata(p_wdata[g]),
      .rdata(q.rd[g])
    );
  end

  function automatic otp_byte_t dflt(input int i);
    dflt = (i == `OTP_UNTRIM_IDX0 || i == `OTP_UNTRIM_IDX1) ?
           `OTP_UNTRIM : 8'h00;
  endfunction : dflt

  always_comb
  begin
    // Bus port wins if both ports ask in one cycle
    pidx = ~p_req[0];
    req = p_req[0] | p_req[1];
    rw = p_rw[pidx];
    addr = p_addr[pidx];
    wdata = p_wdata[pidx];
    hit = 1'b0;
    idx = 4'h0;
    if (addr >= `OTP_BLK0_BASE && addr <= `OTP_BLK0_LAST)
    begin
      hit = 1'b1;
      idx = {1'b0, addr[2:0]};
    end
    else if (addr >= `OTP_BLK1_BASE && addr <= `OTP_BLK1_LAST)
    begin
      hit = 1'b1;
      idx = `OTP_BLK1_IDX + {1'b0, addr[2:0]};
    end
    store_go = req & ~rw & q.unlock & (addr == `OTP_A_CMD) &
               (wdata == `OTP_CMD_STORE) & (q.st == OTP_ST_RUN);
  end

  // ******************************************************************
  // Register file
  // ******************************************************************
  always_comb
  begin
    d = q;
    case (q.st)
      OTP_ST_LOAD:
      begin
        for (int i = 0; i < 14; i++)
        begin
          d.cfg[i] = f.bits[i] ^ dflt(i);
        end
        if (f.passes != 2'h0)
        begin
          d.cfg[`OTP_GAIN_IDX] = f.gain[f.passes - 2'h1] ^
                                 dflt(`OTP_GAIN_IDX);
        end
        d.st = OTP_ST_RUN;
      end
      OTP_ST_RUN:
      begin
        if (req & rw)
        begin
          d.rd[pidx] = 8'h00;
          if (addr == `OTP_A_UNLOCK)
          begin
            d.rd[pidx] = {7'h00, q.unlock};
          end
          else if (addr == `OTP_A_ACCESS)
          begin
            d.rd[pidx] = {6'h00, q.sel};
          end
          else if (hit & q.unlock & (q.sel == `OTP_SEL_READ))
          begin
            d.rd[pidx] = q.cfg[idx];
          end
        end
        else if (req)
        begin
          if (addr == `OTP_A_UNLOCK)
          begin
            d.unlock = wdata[0];
          end
          else if (addr == `OTP_A_ACCESS && q.unlock)
          begin
            d.sel = wdata[1:0];
          end
          else if (addr == `OTP_A_CMD && q.unlock &&
                   wdata == `OTP_CMD_LOAD)
          begin
            d.st = OTP_ST_LOAD;
          end
          else if (hit & q.unlock & (q.sel == `OTP_SEL_WRITE))
          begin
            d.cfg[idx] = wdata;
          end
        end
      end
      default:
      begin
        d.st = OTP_ST_LOAD;
      end
    endcase
    // Registered so the status output comes straight from a flop
    d.done = (d.st == OTP_ST_RUN);
  end

  // Power-on reset clears the volatile registers only
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '{st: OTP_ST_LOAD, sel: `OTP_SEL_RST, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  // ******************************************************************
  // Fuse array
  // ******************************************************************
  always_comb
  begin
    fd = f;
    if (store_go && f.passes < `OTP_PASSES)
    begin
      for (int i = 0; i < 14; i++)
      begin
        if (i != `OTP_GAIN_IDX)
        begin
          fd.bits[i] = f.bits[i] | (q.cfg[i] ^ dflt(i));
        end
      end
      fd.gain[f.passes] = f.gain[f.passes] |
        (q.cfg[`OTP_GAIN_IDX] ^ dflt(`OTP_GAIN_IDX));
      fd.passes = f.passes + 2'h1;
    end
  end

  // Fuses have their own blank-die reset, untouched by power-on reset
  always_ff @(posedge clock or negedge fuse_blank_n)
  begin
    if (!fuse_blank_n)
    begin
      f <= '0;
    end
    else
    begin
      f <= fd;
    end
  end

  assign link.i2c_dev_o = p_o[0];
  assign link.i2c_dev_oe_n = p_oe_n[0];
  assign link.trim_dev_o = p_o[1];
  assign link.trim_dev_oe_n = p_oe_n[1];
  assign cfg_regs = q.cfg;
  assign load_done = q.done;
  assign passes_used = f.passes;
endmodule : otp_dev
`default_nettype wire

// ### design/otp_host.sv
// Host end: drives read and write frames on either serial port
`include "otp_cfg.svh"
`default_nettype none
module otp_host
  import otp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Serial ports
  otp_if.host link,
  // User request
  input wire logic go,
  input wire logic rw,
  input wire logic port_sel,
  input wire logic [6:0] addr,
  input wire otp_byte_t wdata,
  // User answer
  output logic busy,
  output logic done,
  output otp_byte_t rdata
);
  typedef struct packed {
    otp_host_st_t st;
    logic [2:0] div;
    logic [4:0] idx;
    logic [23:0] sh;
    logic rw;
    logic sel;
    logic [1:0] scl;
    logic [1:0] oe_n;
    logic [1:0] s1;
    logic [1:0] s2;
    otp_byte_t rd;
    logic busy;
    logic done;
  } otp_host_t;

  otp_host_t q;
  otp_host_t d;
  logic tick;
  logic [4:0] nxt;
  logic [4:0] total;

  // ******************************************************************
  // Frame sequencer
  // ******************************************************************
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.s1 = {link.trim_serial_data, link.i2c_sda};
    d.s2 = q.s1;
    tick = (q.div == 3'(`OTP_HALF_CYC - 1));
    nxt = q.idx + 5'h01;
    total = q.rw ? `OTP_FRAME_BITS : `OTP_CMD_BITS;
    d.div = (q.st == OTP_H_IDLE || tick) ? 3'h0 : q.div + 3'h1;
    case (q.st)
      OTP_H_IDLE:
      begin
        if (go)
        begin
          d.sel = port_sel;
          d.rw = rw;
          d.sh = {rw, addr, wdata, 8'h00};
          d.idx = 5'h00;
          d.rd = 8'h00;
          d.busy = 1'b1;
          d.oe_n[port_sel] = 1'b0;
          d.st = OTP_H_START;
        end
      end
      OTP_H_START:
      begin
        if (tick)
        begin
          d.scl[q.sel] = 1'b0;
          d.oe_n[q.sel] = q.sh[23];
          d.sh = {q.sh[22:0], 1'b0};
          d.st = OTP_H_LOW;
        end
      end
      OTP_H_LOW:
      begin
        if (tick)
        begin
          d.scl[q.sel] = 1'b1;
          d.st = OTP_H_HIGH;
        end
      end
      OTP_H_HIGH:
      begin
        if (tick)
        begin
          if (q.idx >= `OTP_CMD_BITS)
          begin
            d.rd = {q.rd[6:0], q.s2[q.sel]};
          end
          d.idx = nxt;
          d.scl[q.sel] = 1'b0;
          if (nxt == total)
          begin
            d.oe_n[q.sel] = 1'b0;
            d.st = OTP_H_STOP_LOW;
          end
          else
          begin
            // Release the line for the device's read bits
            d.oe_n[q.sel] = (nxt < `OTP_CMD_BITS) ? q.sh[23] : 1'b1;
            d.sh = {q.sh[22:0], 1'b0};
            d.st = OTP_H_LOW;
          end
        end
      end
      OTP_H_STOP_LOW:
      begin
        if (tick)
        begin
          d.scl[q.sel] = 1'b1;
          d.st = OTP_H_STOP_HIGH;
        end
      end
      OTP_H_STOP_HIGH:
      begin
        if (tick)
        begin
          d.oe_n[q.sel] = 1'b1;
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st = OTP_H_IDLE;
        end
      end
      default:
      begin
        d.st = OTP_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '{st: OTP_H_IDLE, scl: 2'b11, oe_n: 2'b11, s1: 2'b11,
             s2: 2'b11, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign link.i2c_scl = q.scl[0];
  assign link.i2c_host_o = 1'b0;
  assign link.i2c_host_oe_n = q.oe_n[0];
  assign link.trim_serial_clock = q.scl[1];
  assign link.trim_host_o = 1'b0;
  assign link.trim_host_oe_n = q.oe_n[1];
  assign busy = q.busy;
  assign done = q.done;
  assign rdata = q.rd;
endmodule : otp_host
`default_nettype wire

// ### design/otp_if.sv
// Two serial ports (bus port and trim port) joining host and device
`default_nettype none
interface otp_if;
  logic i2c_scl;
  logic i2c_host_o;
  logic i2c_host_oe_n;
  logic i2c_dev_o;
  logic i2c_dev_oe_n;
  logic i2c_sda;
  logic trim_serial_clock;
  logic trim_host_o;
  logic trim_host_oe_n;
  logic trim_dev_o;
  logic trim_dev_oe_n;
  logic trim_serial_data;

  // Open-drain lines with pull-up
  assign i2c_sda = (i2c_host_oe_n | i2c_host_o) & (i2c_dev_oe_n | i2c_dev_o);
  assign trim_serial_data = (trim_host_oe_n | trim_host_o) &
                            (trim_dev_oe_n | trim_dev_o);

  modport dev (
    input i2c_scl, i2c_sda, trim_serial_clock, trim_serial_data,
    output i2c_dev_o, i2c_dev_oe_n, trim_dev_o, trim_dev_oe_n
  );
  modport host (
    input i2c_sda, trim_serial_data,
    output i2c_scl, i2c_host_o, i2c_host_oe_n, trim_serial_clock,
    output trim_host_o, trim_host_oe_n
  );
endinterface : otp_if
`default_nettype wire

// ### design/otp_pkg.sv
// Types shared by both ends of the configuration store link
`default_nettype none
package otp_pkg;
  typedef logic [7:0] otp_byte_t;
  typedef logic [13:0][7:0] otp_cfg_t;
  typedef enum logic [1:0] {OTP_ST_LOAD, OTP_ST_RUN} otp_dev_st_t;
  typedef enum logic [2:0] {
    OTP_H_IDLE, OTP_H_START, OTP_H_LOW, OTP_H_HIGH, OTP_H_STOP_LOW,
    OTP_H_STOP_HIGH
  } otp_host_st_t;
endpackage : otp_pkg
`default_nettype wire
